/* hw/dpl_pkg.sv */
// Shared constants, field layouts and types of the position loop and orientation block
package dpl_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_CLAMP = 8'h08;
    localparam logic [7:0] OFS_TARGET = 8'h0c;
    localparam logic [7:0] OFS_WINDOW = 8'h10;
    localparam logic [7:0] OFS_JOG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_ERROR = 8'h1c;
    localparam logic [7:0] OFS_CORR = 8'h20;
    localparam logic [7:0] OFS_FF = 8'h24;

    // Values after reset
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_GAIN = 32'h0000_1900;   // 25.00 in 8.8 fixed point
    localparam logic [31:0] RST_CLAMP = 32'h0000_0096;  // 150
    localparam logic [31:0] RST_TARGET = 32'h0000_0000;
    localparam logic [31:0] RST_WINDOW = 32'h0000_0100; // 256
    localparam logic [31:0] RST_JOG = 32'h0000_0000;

    // Limits and scaling
    localparam logic [7:0] CLAMP_MAX = 8'hfa;           // 250
    localparam logic [12:0] WINDOW_MAX = 13'h1000;      // 4096
    localparam logic [15:0] NEAR_DIST = 16'h0800;       // 1/32 rev in 1/65536 rev
    localparam int GAIN_SHIFT = 8;

    // Loop mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_RIGID_FF = 3'h1;
    localparam logic [2:0] MODE_RIGID = 3'h2;
    localparam logic [2:0] MODE_SLIP_FF = 3'h3;
    localparam logic [2:0] MODE_SLIP = 3'h4;
    localparam logic [2:0] MODE_OR_STOP = 3'h5;
    localparam logic [2:0] MODE_OR_ALL = 3'h6;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Orientation sequence states
    typedef enum logic [2:0] {OR_IDLE, OR_SEEK, OR_CREEP, OR_LOCK, OR_HOLD, OR_OFF} dpl_ostate_t;

    // Control register layout, bits 9:0
    typedef struct packed {
        logic marker_off_fb;
        logic marker_off_ref;
        logic err_reset;
        logic jog_rev;
        logic jog_en;
        logic hold_zero;
        logic abs_mode;
        logic [2:0] mode;
    } dpl_ctrl_t;

    // Drive condition inputs
    typedef struct packed {
        logic enabled;
        logic src_valid;
        logic fb_init;
        logic at_speed;
        logic stop_cmd;
        logic closed_loop;
    } dpl_drv_t;

endpackage

/* hw/dpl_top.sv */
// Position loop with feed forward, relative jog and spindle orientation, AXI4-Lite registers
`timescale 1ns/1ns
module dpl_top #(
    parameter int ERR_W = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic upd_tick,
    input wire dpl_pkg::dpl_drv_t drv,
    input wire logic [31:0] ref_pos,
    input wire logic [31:0] fb_pos,
    input wire logic ref_marker,
    input wire logic fb_marker,
    input wire logic fb_absolute,
    input wire logic signed [15:0] ramp_speed,
    input wire logic motor_dir_rev,
    output logic signed [15:0] spd_ff,
    output logic signed [15:0] spd_corr,
    output logic signed [15:0] orient_ref,
    output logic ramp_off,
    output logic speed_zero,
    output logic drive_off,
    output logic orient_done,
    output logic stop_override,
    output logic loop_on
);

    // Address decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= dpl_pkg::OFS_FF);
    endfunction

    // Byte lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic [31:0] reg_ctrl, reg_gain, reg_clamp, reg_target, reg_window, reg_jog;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    dpl_pkg::dpl_ctrl_t ctrl;
    logic [7:0] clamp_eff;
    logic [12:0] window_eff;
    logic signed [ERR_W-1:0] err;
    logic [31:0] ref_prev, fb_prev, ref_acc, fb_acc;
    logic primed, ref_mark_pend, fb_mark_pend;
    logic [2:0] mode_q;
    logic abs_q, stop_q, en_q, dir_q;
    dpl_pkg::dpl_ostate_t ostate;

    assign ctrl = reg_ctrl[9:0];
    assign clamp_eff = (reg_clamp[7:0] > dpl_pkg::CLAMP_MAX) ? dpl_pkg::CLAMP_MAX : reg_clamp[7:0];
    assign window_eff = (reg_window[12:0] > dpl_pkg::WINDOW_MAX) ? dpl_pkg::WINDOW_MAX : reg_window[12:0];

    // Write channel: address and data taken in either order, answer after both
    assign do_write = !awready && !wready && !bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= dpl_pkg::RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write)
            begin
                bvalid <= 1'b1;
                bresp <= is_mapped(aw_addr) ? dpl_pkg::RESP_OKAY : dpl_pkg::RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Software registers; status words ignore writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reg_ctrl <= dpl_pkg::RST_CTRL;
            reg_gain <= dpl_pkg::RST_GAIN;
            reg_clamp <= dpl_pkg::RST_CLAMP;
            reg_target <= dpl_pkg::RST_TARGET;
            reg_window <= dpl_pkg::RST_WINDOW;
            reg_jog <= dpl_pkg::RST_JOG;
        end
        else if (do_write)
        begin
            case (aw_addr)
                dpl_pkg::OFS_CTRL: reg_ctrl <= merge(reg_ctrl, w_data, w_strb) & 32'h0000_03ff;
                dpl_pkg::OFS_GAIN: reg_gain <= merge(reg_gain, w_data, w_strb) & 32'h0000_ffff;
                dpl_pkg::OFS_CLAMP: reg_clamp <= merge(reg_clamp, w_data, w_strb) & 32'h0000_00ff;
                dpl_pkg::OFS_TARGET: reg_target <= merge(reg_target, w_data, w_strb) & 32'h0000_ffff;
                dpl_pkg::OFS_WINDOW: reg_window <= merge(reg_window, w_data, w_strb) & 32'h0000_1fff;
                dpl_pkg::OFS_JOG: reg_jog <= merge(reg_jog, w_data, w_strb) & 32'h0000_ffff;
                default: reg_jog <= reg_jog;
            endcase
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dpl_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= is_mapped(araddr) ? dpl_pkg::RESP_OKAY : dpl_pkg::RESP_SLVERR;
            case (araddr)
                dpl_pkg::OFS_CTRL: rdata <= reg_ctrl;
                dpl_pkg::OFS_GAIN: rdata <= reg_gain;
                dpl_pkg::OFS_CLAMP: rdata <= reg_clamp;
                dpl_pkg::OFS_TARGET: rdata <= reg_target;
                dpl_pkg::OFS_WINDOW: rdata <= reg_window;
                dpl_pkg::OFS_JOG: rdata <= reg_jog;
                dpl_pkg::OFS_STATUS: rdata <= {23'h0, ostate, drive_off, speed_zero, ramp_off, stop_override,
                    orient_done, loop_on};
                dpl_pkg::OFS_ERROR: rdata <= err[31:0];
                dpl_pkg::OFS_CORR: rdata <= {{16{spd_corr[15]}}, spd_corr};
                dpl_pkg::OFS_FF: rdata <= {{16{spd_ff[15]}}, spd_ff};
                default: rdata <= 32'h0000_0000;
            endcase
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Per-update position deltas and running positions
    logic [31:0] d_ref, d_fb, next_ref_acc, next_fb_acc;
    assign d_ref = primed ? ref_pos - ref_prev : 32'h0000_0000;
    assign d_fb = primed ? fb_pos - fb_prev : 32'h0000_0000;
    always_comb
    begin
        next_ref_acc = ref_acc + d_ref;
        next_fb_acc = fb_acc + d_fb;
        if ((ref_marker || ref_mark_pend) && !ctrl.marker_off_ref)
        begin
            next_ref_acc = {next_ref_acc[31:16], 16'h0000};
        end
        if ((fb_marker || fb_mark_pend) && !ctrl.marker_off_fb)
        begin
            next_fb_acc = {next_fb_acc[31:16], 16'h0000};
        end
    end

    // Position sources, marker latches and change detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            primed <= 1'b0;
            ref_prev <= 32'h0000_0000;
            fb_prev <= 32'h0000_0000;
            ref_acc <= 32'h0000_0000;
            fb_acc <= 32'h0000_0000;
            ref_mark_pend <= 1'b0;
            fb_mark_pend <= 1'b0;
            mode_q <= dpl_pkg::MODE_OFF;
            abs_q <= 1'b0;
        end
        else if (upd_tick)
        begin
            primed <= 1'b1;
            ref_prev <= ref_pos;
            fb_prev <= fb_pos;
            ref_mark_pend <= 1'b0;
            fb_mark_pend <= 1'b0;
            mode_q <= ctrl.mode;
            abs_q <= ctrl.abs_mode;
            // Non-absolute feedback starts at zero from power-up
            if (!primed)
            begin
                ref_acc <= 32'h0000_0000;
                fb_acc <= fb_absolute ? fb_pos : 32'h0000_0000;
            end
            else
            begin
                ref_acc <= next_ref_acc;
                fb_acc <= next_fb_acc;
            end
        end
        else
        begin
            ref_mark_pend <= ref_mark_pend | ref_marker;
            fb_mark_pend <= fb_mark_pend | fb_marker;
        end
    end

    // Loop enable conditions and integrator load value
    logic rigid, nonrigid, kill, abs_sel, ff_on, orient_en;
    logic signed [ERR_W-1:0] abs_err, jog_d;
    assign rigid = (ctrl.mode == dpl_pkg::MODE_RIGID_FF) || (ctrl.mode == dpl_pkg::MODE_RIGID);
    assign nonrigid = (ctrl.mode == dpl_pkg::MODE_SLIP_FF) || (ctrl.mode == dpl_pkg::MODE_SLIP);
    assign orient_en = ((ctrl.mode == dpl_pkg::MODE_OR_STOP) || (ctrl.mode == dpl_pkg::MODE_OR_ALL)) && drv.closed_loop;
    assign kill = !drv.enabled || !drv.src_valid || !drv.fb_init || (ctrl.mode != mode_q) ||
        (ctrl.abs_mode != abs_q) || ctrl.err_reset || !(rigid || (nonrigid && drv.at_speed));
    assign abs_sel = ctrl.abs_mode && rigid;
    assign abs_err = ERR_W'($signed(next_ref_acc - next_fb_acc));
    // Jog offset moves feedback against reference
    assign jog_d = ctrl.jog_en ? (ctrl.jog_rev ? -ERR_W'($signed({1'b0, reg_jog[15:0]})) :
        ERR_W'($signed({1'b0, reg_jog[15:0]}))) : '0;
    // Internal feed forward only in modes 1 and 3
    assign ff_on = (ctrl.mode == dpl_pkg::MODE_RIGID_FF) || (ctrl.mode == dpl_pkg::MODE_SLIP_FF);

    // Error integrator
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            err <= '0;
        end
        else if (upd_tick)
        begin
            if (kill)
            begin
                err <= abs_sel ? abs_err : '0;
            end
            else
            begin
                err <= err + ERR_W'($signed(d_ref)) - ERR_W'($signed(d_fb)) + jog_d;
            end
        end
    end

    // Orientation error, proportional correction and clamp
    logic signed [15:0] oerr, oabs;
    logic signed [ERR_W-1:0] err_src;
    logic signed [ERR_W+16:0] prod, corr_sh, lim;
    logic signed [15:0] corr_w, seek_ref, ff_w;
    logic near, in_win, locked;
    assign oerr = $signed(reg_target[15:0] - fb_acc[15:0]);
    assign oabs = oerr[15] ? -oerr : oerr;
    assign near = $unsigned(oabs) < dpl_pkg::NEAR_DIST;
    assign in_win = $unsigned(oabs) <= {3'h0, window_eff};
    assign locked = (ostate == dpl_pkg::OR_LOCK) || (ostate == dpl_pkg::OR_HOLD);
    assign err_src = locked ? ERR_W'(oerr) : err;
    assign prod = err_src * $signed({1'b0, reg_gain[15:0]});
    assign corr_sh = prod >>> dpl_pkg::GAIN_SHIFT;
    assign lim = $signed({{(ERR_W + 9){1'b0}}, clamp_eff});
    assign corr_w = (corr_sh > lim) ? 16'(lim) : ((corr_sh < -lim) ? 16'(-lim) : 16'(corr_sh));
    assign seek_ref = dir_q ? -$signed({8'h00, clamp_eff}) : $signed({8'h00, clamp_eff});
    // Reference encoder speed as feed forward
    assign ff_w = ($signed(d_ref) > 32'sd32767) ? 16'sh7fff : (($signed(d_ref) < -32'sd32768) ? -16'sh8000 :
        16'(d_ref));

    // Orientation sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ostate <= dpl_pkg::OR_IDLE;
            stop_q <= 1'b0;
            en_q <= 1'b0;
            dir_q <= 1'b0;
        end
        else if (upd_tick)
        begin
            stop_q <= drv.stop_cmd;
            en_q <= drv.enabled;
            case (ostate)
                dpl_pkg::OR_IDLE:
                begin
                    // Mode 6 with hold_zero set also starts on enable
                    if (orient_en && drv.enabled && ((drv.stop_cmd && !stop_q) ||
                        (ctrl.mode == dpl_pkg::MODE_OR_ALL && ctrl.hold_zero && !en_q)))
                    begin
                        ostate <= dpl_pkg::OR_SEEK;
                        dir_q <= motor_dir_rev;
                    end
                end
                dpl_pkg::OR_SEEK:
                begin
                    if (ramp_speed == seek_ref)
                    begin
                        ostate <= dpl_pkg::OR_CREEP;
                    end
                end
                dpl_pkg::OR_CREEP:
                begin
                    if (near)
                    begin
                        ostate <= dpl_pkg::OR_LOCK;
                    end
                end
                dpl_pkg::OR_LOCK:
                begin
                    if (in_win)
                    begin
                        ostate <= ctrl.hold_zero ? dpl_pkg::OR_HOLD : dpl_pkg::OR_OFF;
                    end
                end
                dpl_pkg::OR_HOLD:
                begin
                    if (!drv.stop_cmd)
                    begin
                        ostate <= dpl_pkg::OR_IDLE;
                    end
                end
                dpl_pkg::OR_OFF:
                begin
                    if (!drv.enabled)
                    begin
                        ostate <= dpl_pkg::OR_IDLE;
                    end
                end
                default: ostate <= dpl_pkg::OR_IDLE;
            endcase
            if (ostate != dpl_pkg::OR_OFF && ostate != dpl_pkg::OR_IDLE && (!orient_en || !drv.enabled))
            begin
                ostate <= dpl_pkg::OR_IDLE;
            end
        end
    end

    // Speed path outputs, refreshed on each update
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            spd_ff <= 16'sh0000;
            spd_corr <= 16'sh0000;
            loop_on <= 1'b0;
        end
        else if (upd_tick)
        begin
            loop_on <= !kill || locked;
            spd_ff <= (ff_on && !kill) ? ff_w : 16'sh0000;
            spd_corr <= (!kill || locked) ? corr_w : 16'sh0000;
        end
    end

    // Orientation outputs follow the sequence state, stop_override follows orient_en
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            orient_ref <= 16'sh0000;
            ramp_off <= 1'b0;
            speed_zero <= 1'b0;
            drive_off <= 1'b0;
            orient_done <= 1'b0;
            stop_override <= 1'b0;
        end
        else
        begin
            orient_ref <= (ostate == dpl_pkg::OR_SEEK || ostate == dpl_pkg::OR_CREEP) ? seek_ref : 16'sh0000;
            ramp_off <= (ostate == dpl_pkg::OR_CREEP) || locked;
            speed_zero <= locked;
            drive_off <= (ostate == dpl_pkg::OR_OFF);
            orient_done <= (locked && in_win) || (ostate == dpl_pkg::OR_OFF);
            stop_override <= orient_en;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_reach_clamp;
        upd_tick && ostate == dpl_pkg::OR_SEEK && ramp_speed == seek_ref && orient_en && drv.enabled;
    endsequence
    sequence s_done_no_hold;
        upd_tick && ostate == dpl_pkg::OR_LOCK && in_win && !ctrl.hold_zero && orient_en && drv.enabled;
    endsequence

    a_kill_stops_loop: assert property (upd_tick && kill && !locked |=> !loop_on)
        else $error("loop stayed on while disabled");
    a_slip_needs_speed: assert property (upd_tick && nonrigid && !drv.at_speed && !locked |=> !loop_on)
        else $error("non-rigid loop ran without at speed");
    a_ff_gate_mode: assert property (upd_tick && (ctrl.mode == dpl_pkg::MODE_RIGID ||
        ctrl.mode == dpl_pkg::MODE_SLIP) |=> spd_ff == 16'sh0000)
        else $error("feed forward present in mode 2 or 4");
    a_corr_clamp_lim: assert property (spd_corr <= 16'sh00fa && spd_corr >= -16'sh00fa)
        else $error("correction beyond 250");
    a_err_zero_load: assert property (upd_tick && kill && !abs_sel |=> err == '0)
        else $error("integrator not zeroed on disable");
    a_err_abs_load: assert property (upd_tick && kill && abs_sel |=> err == $past(abs_err))
        else $error("integrator not loaded with absolute error");
    a_creep_ramps_off: assert property (s_reach_clamp |=> ostate == dpl_pkg::OR_CREEP ##1 ramp_off)
        else $error("ramps not released at clamp speed");
    a_done_in_window: assert property (orient_done |-> $past(locked && in_win) || drive_off)
        else $error("orientation complete outside window");
    a_disable_no_hold: assert property (s_done_no_hold |=> ostate == dpl_pkg::OR_OFF ##1 drive_off)
        else $error("drive not disabled after orientation");
    a_stop_ignored: assert property (orient_en |=> stop_override)
        else $error("stop mode not overridden in orientation");

endmodule

/* tb/dpl_motor.sv */
// Motor model: reference and feedback encoders advancing on each control update
`timescale 1ns/1ns
module dpl_motor (
    input wire logic aclk,
    input wire logic upd_tick,
    input wire logic [31:0] ref_step,
    input wire logic [31:0] fb_step,
    output logic [31:0] ref_pos = 32'h0,
    output logic [31:0] fb_pos = 32'h0
);
    // Both encoders step after the update edge, so the loop sees the old position
    always @(posedge aclk)
    begin
        if (upd_tick)
        begin
            ref_pos <= ref_pos + ref_step;
            fb_pos <= fb_pos + fb_step;
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the position loop block
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, upd_tick = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, ref_step = 32'h0, fb_step = 32'h0, ref_pos, fb_pos, rdata;
    logic [1:0] tcnt = 2'h0, bresp, rresp;
    dpl_pkg::dpl_drv_t drv = 6'h00;
    logic [33:0] exp_q[$];
    logic [33:0] exp_v;
    logic ref_marker = 1'b0, fb_marker = 1'b0, motor_dir_rev = 1'b0;
    logic signed [15:0] orient_ref, ramp_speed = 16'sh0000;
    int error_cnt = 0, compares = 0, step;
    // Clock and a control update every fourth cycle
    always #4 aclk = ~aclk;
    always @(posedge aclk) {tcnt, upd_tick} <= {tcnt + 2'h1, &tcnt};
    // Ramp output reaches the orientation reference one cycle later
    always @(posedge aclk) ramp_speed <= orient_ref;
    dpl_top dpl_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .upd_tick(upd_tick), .drv(drv),
        .ref_pos(ref_pos), .fb_pos(fb_pos), .ref_marker(ref_marker), .fb_marker(fb_marker), .fb_absolute(1'b0),
        .ramp_speed(ramp_speed), .motor_dir_rev(motor_dir_rev), .spd_ff(), .spd_corr(), .orient_ref(orient_ref),
        .ramp_off(), .speed_zero(), .drive_off(), .orient_done(), .stop_override(), .loop_on());
    dpl_motor dpl_motor_inst (.aclk(aclk), .upd_tick(upd_tick), .ref_step(ref_step), .fb_step(fb_step),
        .ref_pos(ref_pos), .fb_pos(fb_pos));
    // Oldest noted read answer against what the bus returns
    always @(posedge aclk)
    begin
        if (rvalid && rready)
        begin
            exp_v = exp_q.pop_front();
            `CHK({rresp, rdata}, exp_v)
        end
    end
    // Verdict and end of run
    task report_and_stop;
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A wait that ran out counts as a mismatch
    task give_up;
        error_cnt++;
        report_and_stop();
    endtask
    // Bus write: address and data offered together, each held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) give_up();
    endtask
    // Bus read: the expected answer is noted before the request goes out
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        exp_q.push_back(e);
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) give_up();
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(38342));
        step = $urandom_range(200, 8);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(dpl_pkg::OFS_GAIN, {2'h0, dpl_pkg::RST_GAIN});
        rd(dpl_pkg::OFS_CLAMP, {2'h0, dpl_pkg::RST_CLAMP});
        rd(dpl_pkg::OFS_WINDOW, {2'h0, dpl_pkg::RST_WINDOW});
        rd(8'h40, {dpl_pkg::RESP_SLVERR, 32'h0});
        $display("test registers done");
        {ref_step, fb_step, drv} <= {step, step >> 1, 6'h3c};
        wr(dpl_pkg::OFS_CTRL, 32'h02);
        repeat (40) @(posedge aclk);
        rd(dpl_pkg::OFS_CORR, 34'h96);
        rd(dpl_pkg::OFS_FF, 34'h0);
        wr(dpl_pkg::OFS_CTRL, 32'h01);
        repeat (40) @(posedge aclk);
        rd(dpl_pkg::OFS_FF, {2'h0, step});
        wr(dpl_pkg::OFS_CLAMP, 32'hff);
        repeat (8) @(posedge aclk);
        rd(dpl_pkg::OFS_CORR, 34'hfa);
        $display("test loop done");
        wr(dpl_pkg::OFS_CTRL, 32'h81);
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_ERROR, 34'h0);
        {ref_step, fb_step, drv} <= {64'h0, 6'h1c};
        wr(dpl_pkg::OFS_CTRL, 32'h09);
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_ERROR, {2'h0, ref_pos - fb_pos});
        {ref_marker, fb_marker} <= 2'h3;
        @(posedge aclk);
        {ref_marker, fb_marker} <= 2'h0;
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_ERROR, {2'h0, {ref_pos[31:16], 16'h0} - {fb_pos[31:16], 16'h0}});
        wr(dpl_pkg::OFS_CTRL, 32'h01);
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_ERROR, 34'h0);
        rd(dpl_pkg::OFS_STATUS, 34'h0);
        $display("test disable done");
        {drv, motor_dir_rev} <= {6'h3d, 1'b1};
        wr(dpl_pkg::OFS_TARGET, 32'h10);
        wr(dpl_pkg::OFS_CTRL, 32'h15);
        repeat (8) @(posedge aclk);
        drv <= 6'h3f;
        repeat (24) @(posedge aclk);
        rd(dpl_pkg::OFS_STATUS, 34'h11f);
        rd(dpl_pkg::OFS_CORR, 34'hfa);
        drv <= 6'h3d;
        wr(dpl_pkg::OFS_CTRL, 32'h05);
        repeat (12) @(posedge aclk);
        drv <= 6'h3f;
        repeat (24) @(posedge aclk);
        rd(dpl_pkg::OFS_STATUS, 34'h166);
        $display("test orientation done");
        drv <= 6'h19;
        wr(dpl_pkg::OFS_CTRL, 32'h04);
        repeat (8) @(posedge aclk);
        drv <= 6'h39;
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_STATUS, 34'h0);
        drv <= 6'h3d;
        repeat (12) @(posedge aclk);
        rd(dpl_pkg::OFS_STATUS, 34'h1);
        wr(dpl_pkg::OFS_JOG, 32'h5);
        wr(dpl_pkg::OFS_CTRL, 32'h64);
        repeat (40) @(posedge aclk);
        rd(dpl_pkg::OFS_CORR, {2'h0, 32'hffff_ff06});
        $display("test slip and jog done");
        report_and_stop();
    end
endmodule
